// [core/tpw_regs.svh]
// Register offsets, field positions, reset values and tick constants of the PWM timer.
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// ********************************************************************
// Register byte offsets, one byte per aligned 32-bit word
// ********************************************************************
`define TPW_ADDR_W         8
`define TPW_OFS_CTRL1      8'h00
`define TPW_OFS_CTRL2      8'h04
`define TPW_OFS_FLAGS      8'h08
`define TPW_OFS_CMP1_HI    8'h0C
`define TPW_OFS_CMP1_LO    8'h10
`define TPW_OFS_CMP2_HI    8'h14
`define TPW_OFS_CMP2_LO    8'h18
`define TPW_OFS_CNT_HI     8'h1C
`define TPW_OFS_CNT_LO     8'h20
`define TPW_OFS_ACNT_HI    8'h24
`define TPW_OFS_ACNT_LO    8'h28
`define TPW_OFS_CAP1_HI    8'h2C
`define TPW_OFS_CAP1_LO    8'h30
`define TPW_OFS_CAP2_HI    8'h34
`define TPW_OFS_CAP2_LO    8'h38

// ********************************************************************
// Field positions of timer_control_one
// ********************************************************************
`define TPW_C1_CAP_IE      7
`define TPW_C1_MATCH_IE    6
`define TPW_C1_OVF_IE      5
`define TPW_C1_FORCE2      4
`define TPW_C1_FORCE1      3
`define TPW_C1_LVL2        2
`define TPW_C1_EDGE1       1
`define TPW_C1_LVL1        0

// ********************************************************************
// Field positions of timer_control_two (flag bit positions are set in the timer core)
// ********************************************************************
`define TPW_C2_OE1         7
`define TPW_C2_OE2         6
`define TPW_C2_SHOT        5
`define TPW_C2_PWM         4
`define TPW_C2_CC_HI       3
`define TPW_C2_CC_LO       2
`define TPW_C2_EDGE2       1
`define TPW_C2_EXT_EDGE    0

// ********************************************************************
// Reset values and tick selection codes
// ********************************************************************
`define TPW_CTRL_RST       8'h00
`define TPW_CMP_RST        16'h8000
`define TPW_CNT_RST        16'hFFFC
`define TPW_CNT_MAX        16'hFFFF
`define TPW_SHOT_CAP_VAL   16'hFFFD
`define TPW_CC_DIV4        2'b00
`define TPW_CC_DIV2        2'b01
`define TPW_CC_DIV8        2'b10
`define TPW_CC_EXT         2'b11
`define TPW_DIV2_MASK      3'b001
`define TPW_DIV4_MASK      3'b011
`define TPW_DIV8_MASK      3'b111

`endif

// [core/tpw_pkg.sv]
// Types shared by the PWM timer modules.
package tpw_pkg;

	// State of the two-flop synchroniser.
	typedef struct packed {
		logic meta;
		logic q;
	} tpw_sync_st_t;

	// State of the tick generator.
	typedef struct packed {
		logic [2:0] div;
		logic       ext_q;
		logic       tick;
	} tpw_tick_st_t;

	// State of the timer core.
	typedef struct packed {
		logic [7:0]  ctrl1;
		logic [7:0]  ctrl2;
		logic [15:0] cmp1;
		logic [15:0] cmp2;
		logic        inh1;
		logic        inh2;
		logic [15:0] cnt;
		logic [15:0] cap1;
		logic [15:0] cap2;
		logic [4:0]  flag;
		logic [4:0]  clr_arm;
		logic        pin1;
		logic        pin2;
		logic        cap1_q;
		logic        cap2_q;
		logic        halt_arm1;
		logic        halt_arm2;
		logic        halt_q;
		logic        dph_wr;
		logic [7:0]  dph_addr;
		logic [7:0]  rdata;
	} tpw_core_st_t;

endpackage : tpw_pkg

// [core/tpw_sync2.sv]
// Two-flop synchroniser for one pin level.
`timescale 1ns/1ns
`default_nettype none

module tpw_sync2 (
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Asynchronous level in, synchronised level out.
	input  wire logic async_in,
	output logic      sync_out
);

	tpw_pkg::tpw_sync_st_t s_r;
	tpw_pkg::tpw_sync_st_t s_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = async_in;
		s_nxt.q    = s_r.meta;
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.q;

endmodule : tpw_sync2
`default_nettype wire

// [core/tpw_tick_gen.sv]
// Timer tick generator: CPU clock divided by 2, 4 or 8, or external clock edges.
`timescale 1ns/1ns
`default_nettype none
`include "tpw_regs.svh"

module tpw_tick_gen #(
	parameter bit HAS_EXT_CLK = 1'b1
) (
	// Clock and reset.
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Control.
	input  wire logic       run,
	input  wire logic [1:0] tick_source_select,
	input  wire logic       ext_rise,
	input  wire logic       ext_lvl,
	// One-cycle tick pulse.
	output logic            tick
);

	tpw_pkg::tpw_tick_st_t s_r;
	tpw_pkg::tpw_tick_st_t s_nxt;

	// The divider runs freely; the selected mask decides which count fires a tick.
	always_comb begin
		logic ext_edge;
		ext_edge      = 1'b0;
		s_nxt         = s_r;
		s_nxt.div     = s_r.div + 3'd1;
		s_nxt.ext_q   = ext_lvl;
		ext_edge      = ext_rise ? (ext_lvl & ~s_r.ext_q) : (~ext_lvl & s_r.ext_q);
		unique case (tick_source_select)
			`TPW_CC_DIV4: s_nxt.tick = run && ((s_r.div & `TPW_DIV4_MASK) == `TPW_DIV4_MASK);
			`TPW_CC_DIV2: s_nxt.tick = run && ((s_r.div & `TPW_DIV2_MASK) == `TPW_DIV2_MASK);
			`TPW_CC_DIV8: s_nxt.tick = run && ((s_r.div & `TPW_DIV8_MASK) == `TPW_DIV8_MASK);
			`TPW_CC_EXT:  s_nxt.tick = run && HAS_EXT_CLK && ext_edge;
		endcase
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule : tpw_tick_gen
`default_nettype wire

// [core/tpw_timer.sv]
// PWM timer core: AHB-Lite registers, counter, compare, capture, flags and interrupt.
// Summary of operation
// - PWM period match reloads counter FFFCh
// - PWM first match drives first level
// - PWM period match drives second level
// - High pulse equals period minus first
// - Equal levels give constant pin
// - High byte write suspends compare
// - PWM never sets match flags
// - PWM period match sets first capture
// - PWM disconnects first capture input
// - PWM wins over single-shot mode
// - Wait keeps running; irq wakes
// - Halt freezes counter, resumes after
// - Halt capture edge arms, completes at exit
// - One shared irq, gated, no halt wake
// - Bit 7 enables capture flag irq
// - Bit 6 enables match flag irq
// - Bit 5 enables overflow flag irq
// - Bit 4 forces second level out
// - Bit 3 forces first level out
// - Bit 2 second level routing
// - Bit 1 selects first capture edge
// - Bit 0 first level on match
// - Compare value N gives N+5 ticks
// - Clock select picks tick source
// - Control two bit 4 enables PWM
// - Flag clear: status read, low access
`timescale 1ns/1ns
`default_nettype none
`include "tpw_regs.svh"

module tpw_timer #(
	parameter bit HAS_EXT_CLK = 1'b1,
	parameter int CNT_W       = 16
) (
	// AHB-Lite clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Timer pins.
	input  wire logic        ext_clk_pin,
	input  wire logic        first_capture_pin,
	input  wire logic        second_capture_pin,
	output logic             first_compare_pin,
	output logic             first_compare_pin_oe,
	output logic             second_compare_pin,
	output logic             second_compare_pin_oe,
	// CPU power and interrupt interface.
	input  wire logic        cpu_irq_mask,
	input  wire logic        cpu_wait,
	input  wire logic        cpu_halt,
	output logic             timer_irq,
	output logic             wait_wake
);

	// ********************************************************************
	// Elaboration checks
	// ********************************************************************
	if (CNT_W != 16) begin : g_bad_width
		$error("tpw_timer only supports a 16-bit counter");
	end

	// Flag vector positions, also their bit positions in the status byte minus three.
	localparam int F_SECOND_MATCH_FLAG = 0;
	localparam int F_SECOND_CAPTURE_FLAG = 1;
	localparam int F_TOF  = 2;
	localparam int F_FIRST_MATCH_FLAG = 3;
	localparam int F_FIRST_CAPTURE_FLAG = 4;

	tpw_pkg::tpw_core_st_t s_r;
	tpw_pkg::tpw_core_st_t s_nxt;

	logic ext_lvl;
	logic cap1_lvl;
	logic cap2_lvl;
	logic tick;

	// ********************************************************************
	// Pin synchronisers and tick source
	// ********************************************************************
	tpw_sync2 u_sync_ext (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (ext_clk_pin),
		.sync_out (ext_lvl)
	);
	tpw_sync2 u_sync_cap1 (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (first_capture_pin),
		.sync_out (cap1_lvl)
	);
	tpw_sync2 u_sync_cap2 (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (second_capture_pin),
		.sync_out (cap2_lvl)
	);

	// Halt gates the tick off, so the counter freezes with its value kept.
	tpw_tick_gen #(
		.HAS_EXT_CLK (HAS_EXT_CLK)
	) u_tick (
		.hclk               (hclk),
		.hresetn            (hresetn),
		.run                (~cpu_halt),
		.tick_source_select (s_r.ctrl2[`TPW_C2_CC_HI:`TPW_C2_CC_LO]),
		.ext_rise           (s_r.ctrl2[`TPW_C2_EXT_EDGE]),
		.ext_lvl            (ext_lvl),
		.tick               (tick)
	);

	// ********************************************************************
	// Decoded events
	// ********************************************************************
	logic       acc;
	logic       rd_acc;
	logic [7:0] a_ofs;
	logic       pwm_mode;
	logic       shot_mode;
	logic       cnt_tick;
	logic       match1;
	logic       match2;
	logic       edge1;
	logic       edge2;
	logic       halt_exit;
	logic       cnt_wr;

	// Address phase is accepted only for an active, selected, ready transfer.
	assign acc       = hsel && hready && htrans[1];
	assign rd_acc    = acc && !hwrite;
	assign a_ofs     = haddr[7:0];
	assign pwm_mode  = s_r.ctrl2[`TPW_C2_PWM];
	assign shot_mode = s_r.ctrl2[`TPW_C2_SHOT] && !pwm_mode;
	assign cnt_tick  = tick && !cpu_halt;
	// A written high byte keeps its compare off until the low byte follows.
	assign match1    = cnt_tick && (s_r.cnt == s_r.cmp1) && !s_r.inh1;
	assign match2    = cnt_tick && (s_r.cnt == s_r.cmp2) && !s_r.inh2;
	// First capture input is ignored entirely while PWM runs.
	assign edge1     = !pwm_mode && (s_r.ctrl1[`TPW_C1_EDGE1] ?
		(cap1_lvl && !s_r.cap1_q) : (!cap1_lvl && s_r.cap1_q));
	assign edge2     = s_r.ctrl2[`TPW_C2_EDGE2] ? (cap2_lvl && !s_r.cap2_q) :
		(!cap2_lvl && s_r.cap2_q);
	assign halt_exit = s_r.halt_q && !cpu_halt;
	assign cnt_wr    = s_r.dph_wr &&
		(s_r.dph_addr == `TPW_OFS_CNT_LO || s_r.dph_addr == `TPW_OFS_ACNT_LO);

	// ********************************************************************
	// Next-state logic
	// ********************************************************************
	always_comb begin
		logic [4:0] set;
		logic [4:0] lo_acc;
		logic [7:0] rd;
		set    = '0;
		lo_acc = '0;
		rd     = '0;
		s_nxt  = s_r;

		// Bus data phase: writes land one cycle after the address phase.
		s_nxt.dph_wr   = acc && hwrite;
		s_nxt.dph_addr = a_ofs;
		if (s_r.dph_wr) begin
			unique case (s_r.dph_addr)
				`TPW_OFS_CTRL1:   s_nxt.ctrl1 = hwdata[7:0];
				`TPW_OFS_CTRL2:   s_nxt.ctrl2 = hwdata[7:0];
				`TPW_OFS_CMP1_HI: begin
					s_nxt.cmp1[15:8] = hwdata[7:0];
					s_nxt.inh1       = 1'b1;
				end
				`TPW_OFS_CMP1_LO: begin
					s_nxt.cmp1[7:0] = hwdata[7:0];
					s_nxt.inh1      = 1'b0;
				end
				`TPW_OFS_CMP2_HI: begin
					s_nxt.cmp2[15:8] = hwdata[7:0];
					s_nxt.inh2       = 1'b1;
				end
				`TPW_OFS_CMP2_LO: begin
					s_nxt.cmp2[7:0] = hwdata[7:0];
					s_nxt.inh2      = 1'b0;
				end
				default: ;
			endcase
		end

		// Read data are sampled at the address phase, so no wait state is needed.
		unique case (a_ofs)
			`TPW_OFS_CTRL1:   rd = s_r.ctrl1;
			`TPW_OFS_CTRL2:   rd = s_r.ctrl2;
			`TPW_OFS_FLAGS:   rd = {s_r.flag, 3'b000};
			`TPW_OFS_CMP1_HI: rd = s_r.cmp1[15:8];
			`TPW_OFS_CMP1_LO: rd = s_r.cmp1[7:0];
			`TPW_OFS_CMP2_HI: rd = s_r.cmp2[15:8];
			`TPW_OFS_CMP2_LO: rd = s_r.cmp2[7:0];
			`TPW_OFS_CNT_HI:  rd = s_r.cnt[15:8];
			`TPW_OFS_CNT_LO:  rd = s_r.cnt[7:0];
			`TPW_OFS_ACNT_HI: rd = s_r.cnt[15:8];
			`TPW_OFS_ACNT_LO: rd = s_r.cnt[7:0];
			`TPW_OFS_CAP1_HI: rd = s_r.cap1[15:8];
			`TPW_OFS_CAP1_LO: rd = s_r.cap1[7:0];
			`TPW_OFS_CAP2_HI: rd = s_r.cap2[15:8];
			`TPW_OFS_CAP2_LO: rd = s_r.cap2[7:0];
			default:          rd = 8'h00;
		endcase
		if (rd_acc) begin
			s_nxt.rdata = rd;
		end

		// Low-byte accesses of either direction finish a flag clear.
		if (acc) begin
			lo_acc[F_FIRST_MATCH_FLAG] = (a_ofs == `TPW_OFS_CMP1_LO);
			lo_acc[F_SECOND_MATCH_FLAG] = (a_ofs == `TPW_OFS_CMP2_LO);
			lo_acc[F_FIRST_CAPTURE_FLAG] = (a_ofs == `TPW_OFS_CAP1_LO);
			lo_acc[F_SECOND_CAPTURE_FLAG] = (a_ofs == `TPW_OFS_CAP2_LO);
			lo_acc[F_TOF]  = (a_ofs == `TPW_OFS_CNT_LO);
		end

		// Free-running counter; the reload to FFFCh gives a period of N+5 ticks.
		s_nxt.halt_q = cpu_halt;
		if (cnt_wr) begin
			s_nxt.cnt = `TPW_CNT_RST;
		end else if (shot_mode && edge1 && !cpu_halt) begin
			s_nxt.cnt = `TPW_CNT_RST;
		end else if (cnt_tick) begin
			if (pwm_mode && match2) begin
				s_nxt.cnt = `TPW_CNT_RST;
			end else begin
				s_nxt.cnt = s_r.cnt + 16'h0001;
			end
		end
		set[F_TOF] = cnt_tick && (s_r.cnt == `TPW_CNT_MAX);

		// Compare outputs by mode; equal levels simply rewrite the same value.
		if (pwm_mode) begin
			// Match flags stay untouched here, so no compare irq can arise.
			if (match1) begin
				s_nxt.pin1 = s_r.ctrl1[`TPW_C1_LVL1];
			end
			if (match2) begin
				s_nxt.pin1     = s_r.ctrl1[`TPW_C1_LVL2];
				set[F_FIRST_CAPTURE_FLAG]    = 1'b1;
			end
		end else if (shot_mode) begin
			if (edge1 && !cpu_halt) begin
				s_nxt.pin1  = s_r.ctrl1[`TPW_C1_LVL2];
				s_nxt.cap1  = `TPW_SHOT_CAP_VAL;
				set[F_FIRST_CAPTURE_FLAG] = 1'b1;
			end
			if (match1) begin
				s_nxt.pin1 = s_r.ctrl1[`TPW_C1_LVL1];
			end
			set[F_SECOND_MATCH_FLAG] = match2;
		end else begin
			if (match1) begin
				s_nxt.pin1  = s_r.ctrl1[`TPW_C1_LVL1];
				set[F_FIRST_MATCH_FLAG] = 1'b1;
			end
			if (match2) begin
				s_nxt.pin2  = s_r.ctrl1[`TPW_C1_LVL2];
				set[F_SECOND_MATCH_FLAG] = 1'b1;
			end
			// Forcing copies the level without a match and sets no flag.
			if (s_r.ctrl1[`TPW_C1_FORCE1]) begin
				s_nxt.pin1 = s_r.ctrl1[`TPW_C1_LVL1];
			end
			if (s_r.ctrl1[`TPW_C1_FORCE2]) begin
				s_nxt.pin2 = s_r.ctrl1[`TPW_C1_LVL2];
			end
		end

		// Input captures; during halt an edge only arms the capture.
		s_nxt.cap1_q = cap1_lvl;
		s_nxt.cap2_q = cap2_lvl;
		if (cpu_halt) begin
			s_nxt.halt_arm1 = s_r.halt_arm1 || (edge1 && !shot_mode);
			s_nxt.halt_arm2 = s_r.halt_arm2 || edge2;
		end else begin
			if (edge1 && !shot_mode) begin
				s_nxt.cap1  = s_r.cnt;
				set[F_FIRST_CAPTURE_FLAG] = 1'b1;
			end
			if (edge2) begin
				s_nxt.cap2  = s_r.cnt;
				set[F_SECOND_CAPTURE_FLAG] = 1'b1;
			end
			if (halt_exit && s_r.halt_arm1) begin
				s_nxt.cap1  = s_r.cnt;
				set[F_FIRST_CAPTURE_FLAG] = 1'b1;
			end
			if (halt_exit && s_r.halt_arm2) begin
				s_nxt.cap2  = s_r.cnt;
				set[F_SECOND_CAPTURE_FLAG] = 1'b1;
			end
			s_nxt.halt_arm1 = 1'b0;
			s_nxt.halt_arm2 = 1'b0;
		end

		// Two-step clear; a new event in the clearing cycle wins.
		for (int i = 0; i < 5; i++) begin
			if (rd_acc && a_ofs == `TPW_OFS_FLAGS && s_r.flag[i]) begin
				s_nxt.clr_arm[i] = 1'b1;
			end else if (lo_acc[i]) begin
				s_nxt.clr_arm[i] = 1'b0;
			end
			s_nxt.flag[i] = set[i] || (s_r.flag[i] && !(s_r.clr_arm[i] && lo_acc[i]));
		end
	end

	// ********************************************************************
	// State register
	// ********************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r       <= '0;
			s_r.ctrl1 <= `TPW_CTRL_RST;
			s_r.ctrl2 <= `TPW_CTRL_RST;
			s_r.cmp1  <= `TPW_CMP_RST;
			s_r.cmp2  <= `TPW_CMP_RST;
			s_r.cnt   <= `TPW_CNT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	logic irq_req;

	// One line for all events; the CPU mask blocks it and halt is never woken.
	assign irq_req = (s_r.ctrl1[`TPW_C1_CAP_IE] &&
			(s_r.flag[F_FIRST_CAPTURE_FLAG] || s_r.flag[F_SECOND_CAPTURE_FLAG])) ||
		(s_r.ctrl1[`TPW_C1_MATCH_IE] &&
			(s_r.flag[F_FIRST_MATCH_FLAG] || s_r.flag[F_SECOND_MATCH_FLAG])) ||
		(s_r.ctrl1[`TPW_C1_OVF_IE] && s_r.flag[F_TOF]);
	assign timer_irq = irq_req && !cpu_irq_mask;
	// Wait does not gate the tick, so only the wake needs logic.
	assign wait_wake = timer_irq && cpu_wait;

	assign hrdata                = {24'h0000_00, s_r.rdata};
	assign hreadyout             = 1'b1;
	assign hresp                 = 1'b0;
	assign first_compare_pin     = s_r.pin1;
	assign first_compare_pin_oe  = s_r.ctrl2[`TPW_C2_OE1];
	assign second_compare_pin    = s_r.pin2;
	assign second_compare_pin_oe = s_r.ctrl2[`TPW_C2_OE2];

	// ********************************************************************
	// Assertions
	// ********************************************************************
	chk_pwm_reload: assert property (@(posedge hclk) disable iff (!hresetn)
		(pwm_mode && match2 && !cnt_wr) |=> (s_r.cnt == 16'hFFFC))
		else $error("PWM period match did not reload counter");
	chk_pwm_first_lvl: assert property (@(posedge hclk) disable iff (!hresetn)
		(pwm_mode && match1 && !match2) |=> (s_r.pin1 == $past(s_r.ctrl1[0])))
		else $error("PWM first match did not drive first level");
	chk_pwm_second_lvl: assert property (@(posedge hclk) disable iff (!hresetn)
		(pwm_mode && match2) |=> (s_r.pin1 == $past(s_r.ctrl1[2])))
		else $error("PWM period match did not drive second level");
	chk_pwm_no_match: assert property (@(posedge hclk) disable iff (!hresetn)
		(pwm_mode && !s_r.flag[F_FIRST_MATCH_FLAG] && !s_r.flag[F_SECOND_MATCH_FLAG]) |=>
		(!s_r.flag[F_FIRST_MATCH_FLAG] && !s_r.flag[F_SECOND_MATCH_FLAG]))
		else $error("Match flag set in PWM mode");
	chk_pwm_cap_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(pwm_mode && match2) |=> s_r.flag[F_FIRST_CAPTURE_FLAG])
		else $error("PWM period match did not set capture flag");
	chk_high_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_r.dph_wr && s_r.dph_addr == `TPW_OFS_CMP1_HI) |=> (s_r.inh1 && !match1))
		else $error("Compare not suspended after high byte write");
	chk_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_irq_mask |-> !timer_irq)
		else $error("Interrupt raised while CPU mask set");
	chk_halt_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		(cpu_halt && !cnt_wr) |=> (s_r.cnt == $past(s_r.cnt)))
		else $error("Counter moved during halt");

endmodule : tpw_timer
`default_nettype wire

// [test/tpw_cpu_model.sv]
// Far-side model: CPU mask and power lines, capture pins and the external clock pin.
`timescale 1ns/1ns
`default_nettype none

module tpw_cpu_model (
	// Clock and wake request from the timer.
	input  wire logic hclk,
	input  wire logic wait_wake,
	// CPU lines and timer input pins.
	output logic      cpu_irq_mask,
	output logic      cpu_wait,
	output logic      cpu_halt,
	output logic      ext_clk_pin,
	output logic      first_capture_pin,
	output logic      second_capture_pin
);
	int   n_wake  = 0;
	logic ext_run = 1'b0;

	// Once started, the external tick clock runs free, one level per hclk cycle.
	always @(posedge hclk) begin
		if (ext_run) begin
			ext_clk_pin <= ~ext_clk_pin;
		end
	end

	// The external clock starts low and stands still until the bench sets ext_run.
	initial begin
		cpu_irq_mask = 1'b1;
		cpu_wait = 1'b0;
		cpu_halt = 1'b0;
		ext_clk_pin = 1'b0;
		first_capture_pin = 1'b0;
		second_capture_pin = 1'b0;
	end

	// A wake request ends the wait state one edge later, as the CPU would.
	always @(posedge hclk) begin
		if (cpu_wait && wait_wake === 1'b1) begin
			cpu_wait <= 1'b0;
			n_wake <= n_wake + 1;
		end
	end

	// Lines change just after a rising edge, whatever the caller last waited for.
	task automatic set_lines(input logic m, input logic w, input logic h);
		@(posedge hclk);
		cpu_irq_mask <= m;
		cpu_wait <= w;
		cpu_halt <= h;
	endtask : set_lines

	// High then low: the falling edge is the active one with edge select 0.
	task automatic pulse_cap(input logic first);
		@(posedge hclk);
		if (first) begin
			first_capture_pin <= 1'b1;
		end else begin
			second_capture_pin <= 1'b1;
		end
		repeat (3) @(posedge hclk);
		first_capture_pin <= 1'b0;
		second_capture_pin <= 1'b0;
	endtask : pulse_cap
endmodule : tpw_cpu_model
`default_nettype wire

// [test/timer16_pwm_irq_ctrl_bench.sv]
// Self-checking bench of the PWM timer through its AHB-Lite registers and pins.
`timescale 1ns/1ns
`default_nettype none

module timer16_pwm_irq_ctrl_bench;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, ext_clk, cap1, cap2, mask, wt, halt;
	logic        pin1, oe1, pin2, oe2, irq, wake;
	int          n_fail = 0;
	int          n_compared = 0;

	// Free-running 50 MHz clock.
	always #10 hclk = ~hclk;

	tpw_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ext_clk_pin(ext_clk), .first_capture_pin(cap1), .second_capture_pin(cap2),
		.first_compare_pin(pin1), .first_compare_pin_oe(oe1),
		.second_compare_pin(pin2), .second_compare_pin_oe(oe2),
		.cpu_irq_mask(mask), .cpu_wait(wt), .cpu_halt(halt), .timer_irq(irq),
		.wait_wake(wake));

	tpw_cpu_model cpu_u (.hclk(hclk), .wait_wake(wake), .cpu_irq_mask(mask),
		.cpu_wait(wt), .cpu_halt(halt), .ext_clk_pin(ext_clk),
		.first_capture_pin(cap1), .second_capture_pin(cap2));

	task automatic finish_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One single transfer; the master waits for hready in each phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr <= {24'h0000_00, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0000_00, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, {8'h00, e}, {8'h00, q});
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(negedge hclk);
	endtask : cyc

	// Pin 1 high and low times in clock cycles, sampled mid-cycle.
	task automatic meas(output logic [15:0] hi, output logic [15:0] lo);
		hi = 16'h0000;
		lo = 16'h0000;
		for (int i = 0; i < 400 && pin1 !== 1'b0; i++) @(negedge hclk);
		for (int i = 0; i < 400 && pin1 !== 1'b1; i++) @(negedge hclk);
		while (pin1 === 1'b1 && hi < 400) begin
			@(negedge hclk);
			hi++;
		end
		while (pin1 === 1'b0 && lo < 400) begin
			@(negedge hclk);
			lo++;
		end
	endtask : meas

	task automatic t_regs();
		rd("ctrl1_rst", 8'h00, 8'h00);
		rd("cmp1_hi_rst", 8'h0C, 8'h80);
		rd("unmapped", 8'h3C, 8'h00);
		chk("hresp_okay", 16'h0000, {15'h0000, hresp});
		wr(8'h00, 8'hA6);
		rd("ctrl1_rw", 8'h00, 8'hA6);
	endtask : t_regs

	task automatic t_force();
		wr(8'h04, 8'hC0);
		wr(8'h00, 8'h1D);
		cyc(2);
		chk("force_high", 16'h000F, {12'h000, pin1, pin2, oe1, oe2});
		wr(8'h00, 8'h18);
		cyc(2);
		chk("force_low", 16'h0003, {12'h000, pin1, pin2, oe1, oe2});
	endtask : t_force

	// Period 0x0010 and pulse edge 0x0006: 21 ticks a period, 10 ticks high.
	// PWM goes on first, so the compare writes can never raise a match flag.
	task automatic t_pwm(input logic [1:0] cc, input int presc);
		logic [15:0] hi, lo;
		wr(8'h04, {4'b1011, cc, 2'b00});
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h10);
		wr(8'h0C, 8'h00);
		wr(8'h10, 8'h06);
		wr(8'h00, 8'h01);
		wr(8'h20, 8'h00);
		meas(hi, lo);
		chk("pwm_high", 16'(10 * presc), hi);
		chk("pwm_period", 16'(21 * presc), hi + lo);
	endtask : t_pwm

	task automatic t_const();
		int bad;
		bad = 0;
		wr(8'h00, 8'h05);
		wr(8'h20, 8'h00);
		cyc(30);
		for (int i = 0; i < 200; i++) begin
			@(negedge hclk);
			if (pin1 !== 1'b1) bad++;
		end
		chk("pwm_const", 16'h0000, 16'(bad));
	endtask : t_const

	task automatic t_irq();
		logic [7:0] q;
		// A first capture pulse while PWM runs must not be captured.
		cpu_u.pulse_cap(1'b1);
		bus(1'b0, 8'h08, 8'h00, q);
		chk("first_capture_flag_pwm", 16'h0001, {15'h0000, q[7]});
		chk("ocf_pwm", 16'h0000, {14'h0000, q[6], q[3]});
		wr(8'h00, 8'h81);
		cpu_u.set_lines(1'b0, 1'b0, 1'b0);
		cyc(2);
		chk("irq_cap", 16'h0001, {15'h0000, irq});
		wr(8'h00, 8'h41);
		cyc(2);
		chk("irq_match", 16'h0000, {15'h0000, irq});
		wr(8'h00, 8'h21);
		cyc(2);
		chk("irq_ovf", 16'h0001, {15'h0000, irq});
		cpu_u.set_lines(1'b1, 1'b0, 1'b0);
		cyc(2);
		chk("irq_masked", 16'h0000, {15'h0000, irq});
		cpu_u.set_lines(1'b0, 1'b1, 1'b0);
		cyc(4);
		chk("wait_wakes", 16'h0001, 16'(cpu_u.n_wake));
	endtask : t_irq

	task automatic t_clr_halt();
		logic [7:0] a, b;
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h00);
		// Overflow and match flags may be up by now, so only the first capture flag is judged.
		bus(1'b0, 8'h08, 8'h00, a);
		chk("flags_arm", 16'h0001, {15'h0000, a[7]});
		// No capture has happened, so the register still holds its cleared value.
		rd("cap1_lo", 8'h30, 8'h00);
		bus(1'b0, 8'h08, 8'h00, a);
		chk("first_capture_flag_clear", 16'h0000, {15'h0000, a[7]});
		cpu_u.set_lines(1'b1, 1'b0, 1'b1);
		cyc(4);
		bus(1'b0, 8'h20, 8'h00, a);
		cpu_u.pulse_cap(1'b0);
		cyc(30);
		bus(1'b0, 8'h20, 8'h00, b);
		chk("halt_freeze", {8'h00, a}, {8'h00, b});
		cpu_u.set_lines(1'b1, 1'b0, 1'b0);
		cyc(4);
		bus(1'b0, 8'h08, 8'h00, a);
		chk("second_capture_flag_halt", 16'h0001, {15'h0000, a[4]});
		rd("cap2_exit", 8'h38, b);
	endtask : t_clr_halt

	// Main sequence after 20 cycles of reset.
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_force();
		t_pwm(2'b00, 4);
		t_pwm(2'b01, 2);
		t_pwm(2'b10, 8);
		// The external clock gives a falling edge every two cycles.
		cpu_u.ext_run <= 1'b1;
		t_pwm(2'b11, 2);
		t_const();
		t_irq();
		t_clr_halt();
		finish_test();
	end

	// Watchdog: the sequence needs about a thousand cycles.
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end
endmodule : timer16_pwm_irq_ctrl_bench
`default_nettype wire
